//--- include/lan_power_pkg.sv
// Notes on behaviour
// RQ1 - External reset input at 1 initialises controller and transceiver logic.
// RQ2 - Link controller disable bit set holds controller logic initialised.
// RQ3 - While disabled, link control, hash and buffer registers keep written values.
// RQ4 - While disabled, twisted-pair transceiver stays powered down.
// RQ5 - Standby_n 0 with shutdown select 0 stops internal clocks, oscillator runs.
// RQ6 - Standby_n 0 with shutdown select 1 stops the crystal oscillator.
// RQ7 - Card mode drives standby_n from the card power-down request.
// RQ8 - Card-mode software never writes standby_n directly.
// RQ9 - Software waits 200 us after reset, may program registers meanwhile.
// RQ10 - Clocks restore on wake; after shutdown wait for oscillator to settle.
package lan_power_pkg;
  localparam logic [31:0] ADDR_LINK_SIX = 32'h0000_0000;
  localparam logic [31:0] ADDR_LINK_SEVEN = 32'h0000_0004;
  localparam logic [31:0] ADDR_BUF_FOURTEEN = 32'h0000_0008;
  localparam logic [31:0] ADDR_CARD_ONE = 32'h0000_000C;
  localparam logic [31:0] ADDR_RESET_CTRL = 32'h0000_0010;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0014;
  localparam int DISABLE_BIT = 7;
  localparam int STANDBY_BIT = 5;
  localparam int SHUTDOWN_BIT = 4;
  localparam int POWER_DOWN_BIT = 2;
  localparam int EXT_RESET_BIT = 0;
  localparam logic [7:0] LINK_SIX_RESET = 8'h80;
  localparam logic [7:0] LINK_SEVEN_RESET = 8'h20;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int WAKE_TIME_US = 200;
  localparam int CLOCK_MHZ = 250;
  localparam int WAKE_CYCLES = WAKE_TIME_US * CLOCK_MHZ;
  localparam int OSC_SETTLE_US = 1000;
  localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_US * CLOCK_MHZ;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_STANDBY = 4'b0010,
    ST_SHUTDOWN = 4'b0100,
    ST_SETTLE = 4'b1000
  } power_state_t;
endpackage : lan_power_pkg

//--- rtl/lan_reset_power_control.sv
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
module lan_reset_power_control
  import lan_power_pkg::*;
#(
  parameter int SETTLE_CYCLES = OSC_SETTLE_CYCLES
)
(
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic EXT_RESET_IN,
  input wire logic CARD_MODE_IN,
  input wire logic [31:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [31:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic CTRL_RESET_OUT,
  output logic XCVR_RESET_OUT,
  output logic XCVR_POWER_DOWN_OUT,
  output logic CORE_CLOCK_GATE_OUT,
  output logic OSC_ENABLE_OUT
);

  logic ext_meta;
  logic ext_sync;
  logic mode_meta;
  logic mode_sync;
  logic [7:0] link_control_reg_six;
  logic [7:0] link_control_reg_seven;
  logic [7:0] buffer_mgmt_reg_fourteen;
  logic [7:0] card_config_reg_one;
  logic soft_ext_reset;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  power_state_t state;
  power_state_t next_state;
  logic [31:0] settle_count;

  // Byte 0 write under strobe
  function automatic logic [7:0] merge_byte(input logic [7:0] old_val, input logic [31:0] data,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? data[7:0] : old_val;
  endfunction : merge_byte

  wire ext_reset = ext_sync | soft_ext_reset;
  wire standby_n = link_control_reg_seven[STANDBY_BIT];
  wire shutdown_select = buffer_mgmt_reg_fourteen[SHUTDOWN_BIT];
  wire link_controller_disable = link_control_reg_six[DISABLE_BIT];
  wire do_write = aw_held & w_held & ~S_AXI_BVALID_OUT;
  wire hit_six = aw_addr == ADDR_LINK_SIX;
  wire hit_seven = aw_addr == ADDR_LINK_SEVEN;
  wire hit_fourteen = aw_addr == ADDR_BUF_FOURTEEN;
  wire hit_card = aw_addr == ADDR_CARD_ONE;
  wire hit_rst = aw_addr == ADDR_RESET_CTRL;
  wire write_hit = hit_six | hit_seven | hit_fourteen | hit_card | hit_rst;
  wire [7:0] seven_written = merge_byte(link_control_reg_seven, w_data, w_strb);
  // Card mode drops software's standby bit, the power-down request owns it
  wire [7:0] seven_masked = CARD_MODE_IN ?
    {seven_written[7:6], link_control_reg_seven[STANDBY_BIT], seven_written[4:0]} :
    seven_written; // see RQ8
  wire do_read = S_AXI_ARVALID_IN & ~S_AXI_RVALID_OUT;
  wire [31:0] rd_byte =
    (S_AXI_ARADDR_IN == ADDR_LINK_SIX) ? {24'h00_0000, link_control_reg_six} :
    (S_AXI_ARADDR_IN == ADDR_LINK_SEVEN) ? {24'h00_0000, link_control_reg_seven} :
    (S_AXI_ARADDR_IN == ADDR_BUF_FOURTEEN) ? {24'h00_0000, buffer_mgmt_reg_fourteen} :
    (S_AXI_ARADDR_IN == ADDR_CARD_ONE) ? {24'h00_0000, card_config_reg_one} :
    (S_AXI_ARADDR_IN == ADDR_RESET_CTRL) ? {31'h0000_0000, soft_ext_reset} :
    {28'h000_0000, state};
  wire read_hit = (S_AXI_ARADDR_IN[31:5] == 27'h000_0000) &
    (S_AXI_ARADDR_IN[4:0] <= ADDR_STATUS[4:0]) & (S_AXI_ARADDR_IN[1:0] == 2'h0);

  assign S_AXI_AWREADY_OUT = ~aw_held;
  assign S_AXI_WREADY_OUT = ~w_held;
  assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      ext_meta <= EXT_RESET_IN;
      ext_sync <= ext_meta;
      mode_meta <= card_config_reg_one[POWER_DOWN_BIT];
      mode_sync <= mode_meta;
    end
  end

  // Bus channels
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RESP_OKAY;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0000_0000;
      S_AXI_RRESP_OUT <= RESP_OKAY;
    end
    else if (CLK_EN_IN)
    begin
      if (S_AXI_AWVALID_IN && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
      end
      if (do_write)
      begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= write_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
      begin
        S_AXI_BVALID_OUT <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (do_read)
      begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RDATA_OUT <= read_hit ? rd_byte : 32'h0000_0000;
        S_AXI_RRESP_OUT <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RREADY_IN)
      begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

  // Registers; the disable bit only reinitialises datapath, never these values
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      link_control_reg_six <= LINK_SIX_RESET;
      link_control_reg_seven <= LINK_SEVEN_RESET;
      buffer_mgmt_reg_fourteen <= BYTE_ZERO;
      card_config_reg_one <= BYTE_ZERO;
      soft_ext_reset <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (ext_reset)
      begin
        link_control_reg_six <= LINK_SIX_RESET; // see RQ1
        link_control_reg_seven <= LINK_SEVEN_RESET; // see RQ1
        buffer_mgmt_reg_fourteen <= BYTE_ZERO; // see RQ1
        card_config_reg_one <= BYTE_ZERO;
      end
      else if (do_write)
      begin
        if (hit_six)
          link_control_reg_six <= merge_byte(link_control_reg_six, w_data, w_strb); // see RQ3
        if (hit_seven)
          link_control_reg_seven <= seven_masked; // see RQ3
        if (hit_fourteen)
          buffer_mgmt_reg_fourteen <= merge_byte(buffer_mgmt_reg_fourteen, w_data, w_strb);
        if (hit_card)
          card_config_reg_one <= merge_byte(card_config_reg_one, w_data, w_strb);
      end
      if (CARD_MODE_IN && !ext_reset)
        link_control_reg_seven[STANDBY_BIT] <= ~mode_sync; // see RQ7
      if (do_write && hit_rst && w_strb[0])
        soft_ext_reset <= w_data[EXT_RESET_BIT];
    end
  end

  // Power state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (!standby_n)
          next_state = shutdown_select ? ST_SHUTDOWN : ST_STANDBY; // see RQ5 RQ6
      ST_STANDBY:
        if (standby_n)
          next_state = ST_RUN; // see RQ10
        else if (shutdown_select)
          next_state = ST_SHUTDOWN; // see RQ6
      ST_SHUTDOWN:
        if (standby_n)
          next_state = ST_SETTLE; // see RQ10
      ST_SETTLE:
        if (settle_count == 32'h0000_0000)
          next_state = ST_RUN; // see RQ10
      default:
        next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state <= ST_RUN;
      settle_count <= 32'h0000_0000;
    end
    else if (CLK_EN_IN)
    begin
      state <= ext_reset ? ST_RUN : next_state;
      if (next_state == ST_SETTLE && state != ST_SETTLE)
        settle_count <= 32'(SETTLE_CYCLES - 1);
      else if (settle_count != 32'h0000_0000)
        settle_count <= settle_count - 32'h0000_0001;
    end
  end

  // Outputs registered so gating never glitches the clock tree
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      CTRL_RESET_OUT <= 1'b1;
      XCVR_RESET_OUT <= 1'b1;
      XCVR_POWER_DOWN_OUT <= 1'b1;
      CORE_CLOCK_GATE_OUT <= 1'b0;
      OSC_ENABLE_OUT <= 1'b1;
    end
    else if (CLK_EN_IN)
    begin
      CTRL_RESET_OUT <= ext_reset | link_controller_disable; // see RQ1 RQ2
      XCVR_RESET_OUT <= ext_reset; // see RQ1
      XCVR_POWER_DOWN_OUT <= link_controller_disable | (next_state != ST_RUN); // see RQ4
      CORE_CLOCK_GATE_OUT <= next_state != ST_RUN; // see RQ5
      OSC_ENABLE_OUT <= next_state != ST_SHUTDOWN; // see RQ6
    end
  end

endmodule : lan_reset_power_control

//--- verification/lan_reset_power_control_props.sv
module lan_reset_power_control_props
(
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic CLK_EN_IN,
  input wire logic EXT_RESET_IN,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic CTRL_RESET_OUT,
  input wire logic XCVR_RESET_OUT,
  input wire logic XCVR_POWER_DOWN_OUT,
  input wire logic CORE_CLOCK_GATE_OUT,
  input wire logic OSC_ENABLE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  chk_osc_gates_clock: assert property (!OSC_ENABLE_OUT |-> CORE_CLOCK_GATE_OUT)
    else $error("oscillator stopped while clocks run");
  chk_gate_powers_down: assert property (CORE_CLOCK_GATE_OUT |-> XCVR_POWER_DOWN_OUT)
    else $error("clocks stopped with transceiver powered");
  chk_ext_reset_both: assert property ((EXT_RESET_IN && CLK_EN_IN) [*5] |->
    CTRL_RESET_OUT && XCVR_RESET_OUT) else $error("external reset not applied");
  chk_ctrl_reset_xcvr: assert property (CTRL_RESET_OUT |->
    XCVR_RESET_OUT || XCVR_POWER_DOWN_OUT) else $error("transceiver active while held");
  chk_settle_gated: assert property ($rose(OSC_ENABLE_OUT) |-> CORE_CLOCK_GATE_OUT)
    else $error("clocks ran before oscillator settled");
  chk_b_holds: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
    else $error("write response dropped");
  chk_r_follows: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && CLK_EN_IN
    |=> S_AXI_RVALID_OUT) else $error("read data late");
  chk_r_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data not held");
endmodule : lan_reset_power_control_props

bind lan_reset_power_control lan_reset_power_control_props u_props (.CLOCK_IN, .ARST_N_IN,
  .CLK_EN_IN, .EXT_RESET_IN, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN,
  .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .S_AXI_RDATA_OUT, .CTRL_RESET_OUT,
  .XCVR_RESET_OUT, .XCVR_POWER_DOWN_OUT, .CORE_CLOCK_GATE_OUT, .OSC_ENABLE_OUT);

//--- verification/lan_reset_power_control_tb.sv
module lan_reset_power_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lan_power_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, ext = 1'b0, card = 1'b0, ce = 1'b1;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [31:0] awa = 32'h0000_0000, wd = 32'h0000_0000, ara = 32'h0000_0000;
  wire awrdy, wrdy, bvld, arrdy, rvld;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] pw;
  int errors = 0, cmp_count = 0;
  // Address, data, {ctrl, power down, gate, osc}, state
  localparam logic [23:0] ROWS [8] = '{24'h00_0011, 24'h08_0011, 24'h04_0072, 24'h04_2011,
    24'h08_1011, 24'h04_0064, 24'h04_2011, 24'h00_80d1};
  always #2 clk = ~clk;
  // Short settle keeps the wake from shutdown inside a few cycles
  lan_reset_power_control #(.SETTLE_CYCLES(4)) u_lan_reset_power_control (
    .CLOCK_IN(clk), .ARST_N_IN(arst_n), .CLK_EN_IN(ce), .EXT_RESET_IN(ext),
    .CARD_MODE_IN(card), .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'h1),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvld), .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvld), .S_AXI_RREADY_IN(rr),
    .CTRL_RESET_OUT(pw[4]), .XCVR_RESET_OUT(pw[3]), .XCVR_POWER_DOWN_OUT(pw[2]),
    .CORE_CLOCK_GATE_OUT(pw[1]), .OSC_ENABLE_OUT(pw[0]));
  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awa <= {24'h00_0000, a};
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end
    while (awv || wv);
    br <= 1'b1;
    do @(posedge clk); while (!bvld);
    br <= 1'b0;
    chk({38'h0, bresp}, {38'h0, er});
  endtask : put
  task automatic get(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    ara <= {24'h00_0000, a};
    arv <= 1'b1;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge clk); while (!rvld);
    rr <= 1'b0;
    chk({6'h0, rresp, rdata}, {6'h0, er, 24'h00_0000, ed});
  endtask : get
  initial
  begin
    repeat (10) @(posedge clk);
    chk({35'h0, pw}, 40'h1d);
    arst_n <= 1'b1;
    get(8'h00, 8'h80, RESP_OKAY);
    get(8'h04, 8'h20, RESP_OKAY);
    // Software wait before the controller is enabled by the first row
    repeat (WAKE_CYCLES) @(posedge clk);
    foreach (ROWS[i])
    begin
      put(ROWS[i][23:16], ROWS[i][15:8], RESP_OKAY);
      repeat (12) @(posedge clk);
      chk({36'h0, pw[4], pw[2:0]}, {36'h0, ROWS[i][7:4]});
      get(8'h14, {4'h0, ROWS[i][3:0]}, RESP_OKAY);
    end
    get(8'h08, 8'h10, RESP_OKAY);
    get(8'h20, 8'h00, RESP_SLVERR);
    put(8'h20, 8'h55, RESP_SLVERR);
    put(8'h08, 8'h00, RESP_OKAY);
    card <= 1'b1;
    put(8'h0c, 8'h04, RESP_OKAY);
    repeat (12) @(posedge clk);
    put(8'h04, 8'h00, RESP_OKAY);
    get(8'h14, 8'h02, RESP_OKAY);
    put(8'h0c, 8'h00, RESP_OKAY);
    repeat (12) @(posedge clk);
    get(8'h04, 8'h20, RESP_OKAY);
    get(8'h14, 8'h01, RESP_OKAY);
    card <= 1'b0;
    put(8'h10, 8'h01, RESP_OKAY);
    repeat (4) @(posedge clk);
    chk({38'h0, pw[4:3]}, 40'h3);
    put(8'h10, 8'h00, RESP_OKAY);
    ext <= 1'b1;
    repeat (6) @(posedge clk);
    chk({38'h0, pw[4:3]}, 40'h3);
    ext <= 1'b0;
    repeat (6) @(posedge clk);
    chk({39'h0, pw[3]}, 40'h0);
    get(8'h00, 8'h80, RESP_OKAY);
    // Enable low must freeze the reset path as well
    ce <= 1'b0;
    ext <= 1'b1;
    repeat (6) @(posedge clk);
    chk({39'h0, pw[3]}, 40'h0);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk({38'h0, pw[4:3]}, 40'h3);
    ext <= 1'b0;
    stop_test();
  end
  // Bus waits have no own bound, so this cuts any hang short
  initial
  begin
    repeat (WAKE_CYCLES + 5000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule : lan_reset_power_control_tb
